/* weigh_key_zero_tare_peak_tb.sv */
// self-checking bench for the panel controller
`timescale 1ns/1ps
module weigh_key_zero_tare_peak_tb;
	typedef struct packed {
		logic [1:0] ek;
		logic [1:0] key;
		logic [2:0] act;
	} wkz_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] key_i;
	logic [31:0] raw_i = 32'h0000_0000;
	logic sample_i = 1'b0, stable_i = 1'b1;
	logic cell_err_i = 1'b0, bus_disc_i = 1'b0, mem_err_i = 1'b0;
	logic [3:0] opt_fail_i = 4'h0;
	logic [1:0] edit_kind_i = 2'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [3:0] wb_sel_i = 4'hF;
	logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o, nv_tare_o, nv_zero_o, rd;
	logic wb_ack_o, net_led_o, peak_view_o, overload_o, act_stb_o;
	logic send_o, zcal_o, factory_o, nv_we_o;
	logic [6:0] err_o;
	logic [2:0] mode_o, act_o, last_act;
	int mismatches = 0, num_checks = 0, n_send = 0, n_nv = 0, n_fact = 0;
	// edit kind, key, expected action; neighbours differ on purpose
	wkz_row_t rows [11] = '{'{2'h1, 2'h0, 3'h5}, '{2'h1, 2'h1, 3'h6},
		'{2'h1, 2'h2, 3'h7}, '{2'h1, 2'h3, 3'h4}, '{2'h2, 2'h0, 3'h1},
		'{2'h2, 2'h1, 3'h2}, '{2'h2, 2'h3, 3'h4}, '{2'h0, 2'h0, 3'h1},
		'{2'h0, 2'h1, 3'h2}, '{2'h0, 2'h3, 3'h4}, '{2'h0, 2'h2, 3'h3}};
	// 250 MHz
	always #2 clk_i = ~clk_i;
	wkz_operator op (.clk_i(clk_i), .key_o(key_i));
	wkz_panel dut (.clk_i, .rst_i, .key_i, .raw_i, .sample_i, .stable_i,
		.cell_err_i, .bus_disc_i, .opt_fail_i, .mem_err_i, .edit_kind_i,
		.wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
		.wb_dat_o, .wb_ack_o, .net_led_o, .peak_view_o, .overload_o, .err_o,
		.mode_o, .act_o, .act_stb_o, .send_o, .zcal_o, .factory_o,
		.nv_we_o, .nv_tare_o, .nv_zero_o);
	// pulse counters, so one-cycle outputs are never missed
	always @(posedge clk_i) begin
		if (send_o === 1'b1) n_send++;
		if (nv_we_o === 1'b1) n_nv++;
		if (factory_o === 1'b1) n_fact++;
		if (act_stb_o === 1'b1) last_act <= act_o;
	end
	task close_out;
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; held until ack is seen at an edge
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			close_out;
		end
		@(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000, rd);
		chk(rd, e);
	endtask
	task automatic smp(input logic [31:0] v);
		raw_i <= v;
		sample_i <= 1'b1;
		@(posedge clk_i);
		sample_i <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
	// short press, then time for sync and the release action
	task automatic press(input int k);
		op.press(k, 6);
		repeat (8) @(posedge clk_i);
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd_chk(wkz_pkg::ADR_CTRL, wkz_pkg::CTRL_RST);
		rd_chk(wkz_pkg::ADR_CAP, wkz_pkg::CAP_RST);
		rd_chk(wkz_pkg::ADR_ZBAND, wkz_pkg::ZBAND_RST);
		rd_chk(8'h3C, 32'h0000_0000);
		wb(1'b1, wkz_pkg::ADR_CTRL, 32'h0000_0001, rd);
		rd_chk(wkz_pkg::ADR_CTRL, 32'h0000_0001);
		{mem_err_i, opt_fail_i, bus_disc_i, cell_err_i} <= 7'h15;
		repeat (6) @(posedge clk_i);
		chk(err_o, 7'h15);
		{mem_err_i, opt_fail_i, bus_disc_i, cell_err_i} <= 7'h2A;
		repeat (6) @(posedge clk_i);
		chk(err_o, 7'h2A);
		{mem_err_i, opt_fail_i, bus_disc_i, cell_err_i} <= 7'h00;
		smp(32'h0000_0005);
		press(wkz_pkg::K_ZERO);
		chk(n_nv, 1);
		chk(nv_zero_o, 32'h0000_0005);
		smp(32'h0000_000B);
		press(wkz_pkg::K_ZERO);
		chk(n_nv, 1);
		press(wkz_pkg::K_FUN);
		chk(net_led_o, 1'b1);
		chk(peak_view_o, 1'b0);
		rd_chk(wkz_pkg::ADR_STAT, 32'h0000_0009);
		rd_chk(wkz_pkg::ADR_NET, 32'h0000_0006);
		press(wkz_pkg::K_ZERO);
		chk(n_nv, 2);
		chk(nv_tare_o, 32'h0000_0006);
		rd_chk(wkz_pkg::ADR_NET, 32'h0000_0000);
		press(wkz_pkg::K_PRG);
		chk(n_send, 1);
		rd_chk(wkz_pkg::ADR_EVT, 32'h0000_0039);
		wb(1'b1, wkz_pkg::ADR_EVT, 32'h0000_0039, rd);
		rd_chk(wkz_pkg::ADR_EVT, 32'h0000_0000);
		smp(32'h0000_271E);
		chk(overload_o, 1'b0);
		smp(32'h0000_271F);
		chk(overload_o, 1'b1);
		smp(32'h0000_000C);
		rd_chk(wkz_pkg::ADR_PEAK, 32'h0000_271A);
		press(wkz_pkg::K_SET);
		chk(mode_o, 3'h1);
		for (int i = 0; i < 11; i++) begin
			edit_kind_i <= rows[i].ek;
			press(rows[i].key);
			chk(last_act, rows[i].act);
		end
		edit_kind_i <= 2'h3;
		mem_err_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		press(wkz_pkg::K_PRG);
		chk(n_fact, 1);
		chk(n_send, 1);
		rd_chk(wkz_pkg::ADR_EVT, 32'h0000_0004);
		rd_chk(wkz_pkg::ADR_TARE, 32'h0000_0000);
		rd_chk(wkz_pkg::ADR_ZERO, 32'h0000_0000);
		mem_err_i <= 1'b0;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({net_led_o, mode_o}, 4'h0);
		rd_chk(wkz_pkg::ADR_CTRL, wkz_pkg::CTRL_RST);
		close_out;
	end
endmodule

/* wkz_operator.sv */
// operator model pressing the front panel keys
`timescale 1ns/1ps
module wkz_operator (
	// clock
	input wire logic clk_i,
	// key pins, high while pressed
	output logic [3:0] key_o
);
	// released keys fall back to the pull-down level
	initial key_o = 4'h0;
	// hold one key some cycles; long holds need seconds, so a run
	// only fits short presses
	task press(input int k, input int hold);
		key_o[k] <= 1'b1;
		repeat (hold) @(posedge clk_i);
		key_o <= 4'h0;
	endtask
endmodule

/* wkz_panel.sv */
// front panel key decoder with zero, tare and peak handling
`timescale 1ns/1ps
module wkz_panel (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// keys from panel pins, active high
	input wire logic [3:0] key_i,
	// weighing front end
	input wire logic signed [31:0] raw_i,
	input wire logic sample_i,
	input wire logic stable_i,
	input wire logic cell_err_i,
	input wire logic bus_disc_i,
	input wire logic [3:0] opt_fail_i,
	input wire logic mem_err_i,
	// menu engine status
	input wire logic [1:0] edit_kind_i,
	// wishbone slave
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// display and menu outputs
	output logic net_led_o,
	output logic peak_view_o,
	output logic overload_o,
	output logic [6:0] err_o,
	output logic [2:0] mode_o,
	output logic [2:0] act_o,
	output logic act_stb_o,
	output logic send_o,
	output logic zcal_o,
	output logic factory_o,
	// nonvolatile store write
	output logic nv_we_o,
	output logic [31:0] nv_tare_o,
	output logic [31:0] nv_zero_o
);
	logic [3:0] k1_ff, k2_ff, kp_ff;
	logic [31:0] hold_ff;
	logic used_ff;
	logic [31:0] ctrl_ff, cap_ff, zband_ff, evt_ff;
	logic signed [31:0] tare_ff, zero_ff, peak_ff;
	logic [31:0] zacc_ff;
	logic net_ff, pk_ff;
	wkz_pkg::wkz_mode_t mode_ff;
	logic pend_ff, pend_tare_ff;
	logic [31:0] stab_ff;
	logic signed [31:0] gross, net;
	logic [3:0] rel;
	logic chord, hold_hit, zhit, lng_fun, lng_prg;
	logic short_evt, tare_req, zero_req, do_op, ok_tare, ok_zero;
	logic [2:0] act;
	logic [31:0] ev_set;
	logic [31:0] mag;
	logic commit;

	// absolute value, used for band checks
	function automatic logic [31:0] absv(input logic signed [31:0] v);
		absv = v[31] ? 32'(-v) : 32'(v);
	endfunction

	// three flops per key: two since they come from pins, one more for the release edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			k1_ff <= 4'h0;
			k2_ff <= 4'h0;
			kp_ff <= 4'h0;
		end else begin
			k1_ff <= key_i;
			k2_ff <= k1_ff;
			kp_ff <= k2_ff;
		end
	end

	assign rel = kp_ff & ~k2_ff;
	assign gross = raw_i - zero_ff;
	assign net = gross - tare_ff;
	assign chord = k2_ff[wkz_pkg::K_PRG] &
		(k2_ff[wkz_pkg::K_SET] | k2_ff[wkz_pkg::K_ZERO]);
	assign hold_hit = (hold_ff == wkz_pkg::HOLD_CYC - 1);
	assign zhit = (hold_ff == wkz_pkg::ZCAL_CYC - 1);
	assign lng_fun = k2_ff[wkz_pkg::K_FUN] & hold_hit;
	assign lng_prg = k2_ff[wkz_pkg::K_PRG] &
		(hold_ff == wkz_pkg::LONG_CYC - 1);

	// hold timer runs while any key is down; reaching a long-hold threshold marks the press
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_ff <= 32'h0000_0000;
			used_ff <= 1'b0;
		end else if (k2_ff == 4'h0) begin
			hold_ff <= 32'h0000_0000;
			used_ff <= 1'b0;
		end else begin
			hold_ff <= hold_ff + 32'h0000_0001;
			if (hold_hit | zhit | lng_prg)
				used_ff <= 1'b1;
		end
	end

	// short press: a key released before any long-hold threshold was reached
	assign short_evt = (rel != 4'h0) & ~used_ff & (k2_ff == 4'h0);
	assign tare_req = (mode_ff == wkz_pkg::WKZ_WEIGHT) & short_evt &
		rel[wkz_pkg::K_ZERO] & net_ff & ~pk_ff;
	assign zero_req = (mode_ff == wkz_pkg::WKZ_WEIGHT) & short_evt &
		rel[wkz_pkg::K_ZERO] & ~net_ff & ~pk_ff;
	assign ok_tare = (gross > 0) && (gross <= $signed(cap_ff));
	assign mag = absv(gross);
	// band check and accumulated total, both within the zero band
	assign ok_zero = (mag <= zband_ff) &&
		(zacc_ff + mag <= zband_ff);

	// menu action decode per mode
	always_comb begin
		act = wkz_pkg::WKZ_ACT_NONE;
		if (short_evt) begin
			case (mode_ff)
			wkz_pkg::WKZ_NUMERIC: begin
				if (rel[wkz_pkg::K_SET]) act = wkz_pkg::WKZ_ACT_INC;
				else if (rel[wkz_pkg::K_FUN]) act = wkz_pkg::WKZ_ACT_DEC;
				else if (rel[wkz_pkg::K_ZERO]) act = wkz_pkg::WKZ_ACT_DIGIT;
				else if (rel[wkz_pkg::K_PRG]) act = wkz_pkg::WKZ_ACT_ENTER;
			end
			wkz_pkg::WKZ_LIST: begin
				if (rel[wkz_pkg::K_SET]) act = wkz_pkg::WKZ_ACT_NEXT;
				else if (rel[wkz_pkg::K_FUN]) act = wkz_pkg::WKZ_ACT_PREV;
				else if (rel[wkz_pkg::K_PRG]) act = wkz_pkg::WKZ_ACT_ENTER;
			end
			wkz_pkg::WKZ_SETPT, wkz_pkg::WKZ_QUICK, wkz_pkg::WKZ_SETUP,
			wkz_pkg::WKZ_LOCK: begin
				if (rel[wkz_pkg::K_SET]) act = wkz_pkg::WKZ_ACT_NEXT;
				else if (rel[wkz_pkg::K_FUN]) act = wkz_pkg::WKZ_ACT_PREV;
				else if (rel[wkz_pkg::K_ZERO]) act = wkz_pkg::WKZ_ACT_EXIT;
				else if (rel[wkz_pkg::K_PRG]) act = wkz_pkg::WKZ_ACT_ENTER;
			end
			default: act = wkz_pkg::WKZ_ACT_NONE;
			endcase
		end
	end

	// operating mode; the menu engine reports numeric or list editing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= wkz_pkg::WKZ_WEIGHT;
		end else if (mem_err_i && mode_ff == wkz_pkg::WKZ_WEIGHT) begin
			mode_ff <= wkz_pkg::WKZ_MEMERR;
		end else begin
			case (mode_ff)
			wkz_pkg::WKZ_WEIGHT: begin
				if (k2_ff[wkz_pkg::K_PRG] & k2_ff[wkz_pkg::K_SET] & hold_hit)
					mode_ff <= wkz_pkg::WKZ_SETUP;
				else if (k2_ff[wkz_pkg::K_PRG] & k2_ff[wkz_pkg::K_ZERO] &
					hold_hit)
					mode_ff <= wkz_pkg::WKZ_LOCK;
				else if (lng_prg & ~chord)
					mode_ff <= wkz_pkg::WKZ_QUICK;
				else if (short_evt & rel[wkz_pkg::K_SET])
					mode_ff <= wkz_pkg::WKZ_SETPT;
			end
			wkz_pkg::WKZ_MEMERR: begin
				if (short_evt & rel[wkz_pkg::K_PRG])
					mode_ff <= wkz_pkg::WKZ_WEIGHT;
			end
			wkz_pkg::WKZ_NUMERIC, wkz_pkg::WKZ_LIST: begin
				// follow the engine straight between numeric and list entry,
				// otherwise list keys would still be decoded as digit edits
				if (edit_kind_i == 2'b00)
					mode_ff <= wkz_pkg::WKZ_SETUP;
				else if (edit_kind_i == 2'b01)
					mode_ff <= wkz_pkg::WKZ_NUMERIC;
				else if (edit_kind_i == 2'b10)
					mode_ff <= wkz_pkg::WKZ_LIST;
				else
					mode_ff <= wkz_pkg::WKZ_WEIGHT; // engine left the menu
			end
			default: begin
				if (edit_kind_i == 2'b01)
					mode_ff <= wkz_pkg::WKZ_NUMERIC;
				else if (edit_kind_i == 2'b10)
					mode_ff <= wkz_pkg::WKZ_LIST;
				else if (edit_kind_i == 2'b11)
					mode_ff <= wkz_pkg::WKZ_WEIGHT; // engine left the menu
			end
			endcase
		end
	end

	// gross/net and weight/peak views
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			net_ff <= 1'b0;
			pk_ff <= 1'b0;
		end else if (mode_ff == wkz_pkg::WKZ_WEIGHT) begin
			if (lng_fun & ~chord)
				pk_ff <= ~pk_ff;
			else if (short_evt & rel[wkz_pkg::K_FUN])
				net_ff <= ~net_ff;
		end
	end

	// stability wait; a pending command dies after the window
	assign do_op = pend_ff & stable_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_ff <= 1'b0;
			pend_tare_ff <= 1'b0;
			stab_ff <= 32'h0000_0000;
		end else if (tare_req | zero_req) begin
			// level zero acts at once by marking stable below
			pend_ff <= 1'b1;
			pend_tare_ff <= tare_req;
			stab_ff <= 32'h0000_0000;
		end else if (pend_ff) begin
			if (do_op | (ctrl_ff[wkz_pkg::CTL_STAB_LO +: wkz_pkg::CTL_STAB_W]
				== 3'h0) | (stab_ff == wkz_pkg::STAB_CYC - 1))
				pend_ff <= 1'b0;
			stab_ff <= stab_ff + 32'h0000_0001;
		end
	end

	// a pending command commits once stable, or at once with the check off
	assign commit = pend_ff & (stable_i |
		(ctrl_ff[wkz_pkg::CTL_STAB_LO +: wkz_pkg::CTL_STAB_W] == 3'h0));

	// tare, zero, accumulator, peak; committed values go to the store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tare_ff <= 32'sh0000_0000;
			zero_ff <= 32'sh0000_0000;
			zacc_ff <= 32'h0000_0000;
			peak_ff <= 32'sh8000_0000;
			nv_we_o <= 1'b0;
		end else begin
			nv_we_o <= 1'b0;
			if (commit & pend_tare_ff & ok_tare) begin
				tare_ff <= gross;
				nv_we_o <= 1'b1;
			end else if (commit & ~pend_tare_ff & ok_zero) begin
				zero_ff <= raw_i;
				zacc_ff <= zacc_ff + mag;
				nv_we_o <= 1'b1;
			end
			if (mode_ff == wkz_pkg::WKZ_MEMERR && short_evt &&
				rel[wkz_pkg::K_PRG]) begin
				tare_ff <= 32'sh0000_0000;
				zero_ff <= 32'sh0000_0000;
				zacc_ff <= 32'h0000_0000;
			end else if (pk_ff && mode_ff == wkz_pkg::WKZ_WEIGHT &&
				short_evt && rel[wkz_pkg::K_ZERO]) begin
				// in peak view the zero key clears the peak, not the zero
				peak_ff <= gross; // clearing the peak shown
			end else if (sample_i && gross > peak_ff) begin
				peak_ff <= gross;
			end
		end
	end

	// event pulses and sticky event word for software
	always_comb begin
		ev_set = 32'h0000_0000;
		ev_set[wkz_pkg::EV_SEND] = (mode_ff == wkz_pkg::WKZ_WEIGHT) &
			short_evt & rel[wkz_pkg::K_PRG];
		ev_set[wkz_pkg::EV_ZCAL] = (mode_ff == wkz_pkg::WKZ_WEIGHT) &
			k2_ff[wkz_pkg::K_ZERO] & ~chord & zhit &
			ctrl_ff[wkz_pkg::CTL_ZCAL_EN];
		ev_set[wkz_pkg::EV_FACT] = (mode_ff == wkz_pkg::WKZ_MEMERR) &
			short_evt & rel[wkz_pkg::K_PRG];
		ev_set[wkz_pkg::EV_TARE] = tare_req;
		ev_set[wkz_pkg::EV_ZERO] = zero_req;
		ev_set[wkz_pkg::EV_REFUSE] = (tare_req & ~ok_tare) |
			(zero_req & ~ok_zero);
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_o <= 3'h0;
			act_stb_o <= 1'b0;
			send_o <= 1'b0;
			zcal_o <= 1'b0;
			factory_o <= 1'b0;
			net_led_o <= 1'b0;
			peak_view_o <= 1'b0;
			overload_o <= 1'b0;
			err_o <= 7'h00;
			mode_o <= 3'h0;
			nv_tare_o <= 32'h0000_0000;
			nv_zero_o <= 32'h0000_0000;
		end else begin
			act_o <= act;
			act_stb_o <= (act != wkz_pkg::WKZ_ACT_NONE);
			send_o <= ev_set[wkz_pkg::EV_SEND];
			zcal_o <= ev_set[wkz_pkg::EV_ZCAL];
			factory_o <= ev_set[wkz_pkg::EV_FACT];
			net_led_o <= net_ff;
			peak_view_o <= pk_ff;
			overload_o <= (gross > $signed(cap_ff + wkz_pkg::OVL_DIV));
			err_o <= {mem_err_i, opt_fail_i, bus_disc_i, cell_err_i};
			mode_o <= mode_ff;
			nv_tare_o <= tare_ff;
			nv_zero_o <= zero_ff;
		end
	end

	// wishbone slave: one wait state, write one to clear events
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl_ff <= wkz_pkg::CTRL_RST;
			cap_ff <= wkz_pkg::CAP_RST;
			zband_ff <= wkz_pkg::ZBAND_RST;
			evt_ff <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			// set wins over a clear in the same cycle
			if (wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i &
				wb_adr_i == wkz_pkg::ADR_EVT & wb_sel_i[0])
				evt_ff <= (evt_ff & ~wb_dat_i) | ev_set;
			else
				evt_ff <= evt_ff | ev_set;
			if (wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & (&wb_sel_i)) begin
				case (wb_adr_i)
				wkz_pkg::ADR_CTRL: ctrl_ff <= wb_dat_i;
				wkz_pkg::ADR_CAP: cap_ff <= wb_dat_i;
				wkz_pkg::ADR_ZBAND: zband_ff <= wb_dat_i;
				default: ;
				endcase
			end
			case (wb_adr_i)
			wkz_pkg::ADR_CTRL: wb_dat_o <= ctrl_ff;
			wkz_pkg::ADR_STAT: wb_dat_o <= {25'h0, mode_ff, stable_i,
				overload_o, pk_ff, net_ff};
			wkz_pkg::ADR_CAP: wb_dat_o <= cap_ff;
			wkz_pkg::ADR_ZBAND: wb_dat_o <= zband_ff;
			wkz_pkg::ADR_TARE: wb_dat_o <= tare_ff;
			wkz_pkg::ADR_ZERO: wb_dat_o <= zero_ff;
			wkz_pkg::ADR_PEAK: wb_dat_o <= peak_ff;
			wkz_pkg::ADR_NET: wb_dat_o <= net_ff ? net : gross;
			wkz_pkg::ADR_EVT: wb_dat_o <= evt_ff;
			default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule

/* wkz_panel_asserts.sv */
// concurrent checks on the panel controller ports
`timescale 1ns/1ps
module wkz_panel_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched inputs
	input wire logic [3:0] key_i,
	input wire logic cell_err_i,
	input wire logic bus_disc_i,
	input wire logic [3:0] opt_fail_i,
	input wire logic mem_err_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	// watched outputs
	input wire logic wb_ack_o,
	input wire logic net_led_o,
	input wire logic [6:0] err_o,
	input wire logic [2:0] mode_o,
	input wire logic [2:0] act_o,
	input wire logic act_stb_o,
	input wire logic send_o,
	input wire logic factory_o,
	input wire logic nv_we_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [6:0] flt;
	// fault inputs packed in the order of the error flags
	assign flt = {mem_err_i, opt_fail_i, bus_disc_i, cell_err_i};
	// long enough to cover the one output register delay
	sequence s_flt_quiet;
		$stable(flt) [*4];
	endsequence
	property p_err_map;
		s_flt_quiet |-> err_o == flt;
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("fault flags do not follow inputs");
	property p_net_mode;
		$changed(net_led_o) |-> $past(mode_o) == wkz_pkg::WKZ_WEIGHT;
	endproperty
	a_net_mode: assert property (p_net_mode)
		else $error("net view changed outside weight view");
	property p_send_pulse;
		send_o |=> !send_o;
	endproperty
	a_send_pulse: assert property (p_send_pulse)
		else $error("send pulse too long");
	property p_send_rel;
		send_o |-> !key_i[wkz_pkg::K_PRG] && mode_o == wkz_pkg::WKZ_WEIGHT;
	endproperty
	a_send_rel: assert property (p_send_rel)
		else $error("send before release or outside weight view");
	property p_fact;
		factory_o |-> err_o[6];
	endproperty
	a_fact: assert property (p_fact)
		else $error("restore without memory error");
	property p_nv_pulse;
		nv_we_o |=> !nv_we_o;
	endproperty
	a_nv_pulse: assert property (p_nv_pulse)
		else $error("store write pulse too long");
	property p_act_menu;
		act_stb_o |-> mode_o != wkz_pkg::WKZ_WEIGHT;
	endproperty
	a_act_menu: assert property (p_act_menu)
		else $error("menu action in weight view");
	property p_act_num;
		act_stb_o && (act_o inside {3'h5, 3'h6, 3'h7}) |->
			mode_o == wkz_pkg::WKZ_NUMERIC;
	endproperty
	a_act_num: assert property (p_act_num)
		else $error("digit action outside numeric entry");
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus request not answered next cycle");
	property p_ack_drop;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop)
		else $error("bus answer held too long");
endmodule
bind wkz_panel wkz_panel_chk u_chk (.clk_i, .rst_i, .key_i, .cell_err_i,
	.bus_disc_i, .opt_fail_i, .mem_err_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .net_led_o, .err_o, .mode_o, .act_o, .act_stb_o, .send_o,
	.factory_o, .nv_we_o);

/* wkz_pkg.sv */
// package for the weigh key, zero, tare and peak controller
package wkz_pkg;
	// clock and time figures
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned HOLD_MS = 3000;
	localparam int unsigned ZCAL_MS = 5000;
	localparam int unsigned STAB_MS = 3000;
	localparam int unsigned LONG_MS = 1000;
	localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
	localparam int unsigned ZCAL_CYC = (CLK_HZ / 1000) * ZCAL_MS;
	localparam int unsigned STAB_CYC = (CLK_HZ / 1000) * STAB_MS;
	localparam int unsigned LONG_CYC = (CLK_HZ / 1000) * LONG_MS;
	// overload margin in divisions
	localparam logic [31:0] OVL_DIV = 32'h0000_0009;
	// wishbone register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_CAP = 8'h08;
	localparam logic [7:0] ADR_ZBAND = 8'h0C;
	localparam logic [7:0] ADR_TARE = 8'h10;
	localparam logic [7:0] ADR_ZERO = 8'h14;
	localparam logic [7:0] ADR_PEAK = 8'h18;
	localparam logic [7:0] ADR_NET = 8'h1C;
	localparam logic [7:0] ADR_EVT = 8'h20;
	// ctrl fields
	localparam int CTL_ZCAL_EN = 0;
	localparam int CTL_STAB_LO = 1;
	localparam int CTL_STAB_W = 3;
	// status fields
	localparam int ST_NET = 0;
	localparam int ST_PEAK = 1;
	localparam int ST_OVL = 2;
	localparam int ST_STABLE = 3;
	localparam int ST_MODE_LO = 4;
	// event fields
	localparam int EV_SEND = 0;
	localparam int EV_ZCAL = 1;
	localparam int EV_FACT = 2;
	localparam int EV_TARE = 3;
	localparam int EV_ZERO = 4;
	localparam int EV_REFUSE = 5;
	// reset values
	localparam logic [31:0] CAP_RST = 32'h0000_2710;
	localparam logic [31:0] ZBAND_RST = 32'h0000_000A;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// key bit positions
	localparam int K_SET = 0;
	localparam int K_FUN = 1;
	localparam int K_ZERO = 2;
	localparam int K_PRG = 3;
	// operating modes
	typedef enum logic [2:0] {
		WKZ_WEIGHT, WKZ_SETPT, WKZ_QUICK, WKZ_SETUP, WKZ_LOCK,
		WKZ_NUMERIC, WKZ_LIST, WKZ_MEMERR
	} wkz_mode_t;
	// key action codes sent to the menu engine
	typedef enum logic [2:0] {
		WKZ_ACT_NONE, WKZ_ACT_NEXT, WKZ_ACT_PREV, WKZ_ACT_EXIT,
		WKZ_ACT_ENTER, WKZ_ACT_INC, WKZ_ACT_DEC, WKZ_ACT_DIGIT
	} wkz_act_t;
endpackage
